/* hw/fault_irq_pkg.sv */
// Register map, field layout, reset values and timing for the fault interrupt mask and latch block.
package fault_irq_pkg;

    // Register indexes; the byte address of each register is four times its index.
    localparam logic [7:0] IDX_INTERRUPT_CONFIG = 8'h28;
    localparam logic [7:0] IDX_SYSTEM_EVENT_MASK = 8'h29;
    localparam logic [7:0] IDX_CHANNEL_FAULT_MASK = 8'h2a;
    localparam logic [7:0] IDX_FAULT_TYPE_MASK = 8'h2b;
    localparam logic [7:0] IDX_SYSTEM_EVENT_LATCHED_STATUS = 8'h2c;

    localparam int ADDR_WIDTH = 12;
    localparam logic [11:0] ADDR_INTERRUPT_CONFIG = {2'b00, IDX_INTERRUPT_CONFIG, 2'b00};
    localparam logic [11:0] ADDR_SYSTEM_EVENT_MASK = {2'b00, IDX_SYSTEM_EVENT_MASK, 2'b00};
    localparam logic [11:0] ADDR_CHANNEL_FAULT_MASK = {2'b00, IDX_CHANNEL_FAULT_MASK, 2'b00};
    localparam logic [11:0] ADDR_FAULT_TYPE_MASK = {2'b00, IDX_FAULT_TYPE_MASK, 2'b00};
    localparam logic [11:0] ADDR_SYSTEM_EVENT_LATCHED_STATUS =
        {2'b00, IDX_SYSTEM_EVENT_LATCHED_STATUS, 2'b00};

    // Reset values.
    localparam logic [7:0] RESET_INTERRUPT_CONFIG = 8'h00;
    localparam logic [7:0] RESET_SYSTEM_EVENT_MASK = 8'hff;
    localparam logic [7:0] RESET_CHANNEL_FAULT_MASK = 8'h03;
    localparam logic [7:0] RESET_FAULT_TYPE_MASK = 8'h00;
    localparam logic [3:0] RESET_SYSTEM_EVENT_LATCHED = 4'h0;

    // Field positions of the interrupt configuration register.
    localparam int POS_IRQ_POLARITY_SELECT = 7;
    localparam int POS_EVENT_MODE_LO = 5;
    localparam int POS_LATCH_READBACK_FILTER = 2;
    localparam int POS_LATCH_CLEAR_POLICY = 0;

    // System event bits 7..4: serial port clock error, PLL lock, over-temperature, over-current.
    localparam int POS_SYSTEM_EVENT_LO = 4;
    localparam int SYSTEM_EVENT_COUNT = 4;
    localparam int CHANNEL_COUNT = 4;
    localparam int FAULT_TYPE_COUNT = 8;

    // Interrupt event modes.
    localparam logic [1:0] EVENT_LEVEL = 2'h0;
    localparam logic [1:0] EVENT_REPEAT = 2'h2;
    localparam logic [1:0] EVENT_ONCE = 2'h3;

    // Pulse timing of the repeating and one-shot event modes.
    localparam int CLOCK_HZ = 10_000_000;
    localparam int PULSE_ON_US = 2000;
    localparam int PULSE_PERIOD_US = 4000;
    localparam int PULSE_ON_CYCLES = (PULSE_ON_US * (CLOCK_HZ / 1_000_000));
    localparam int PULSE_PERIOD_CYCLES = (PULSE_PERIOD_US * (CLOCK_HZ / 1_000_000));

    typedef struct packed {
        logic irq_polarity_select;
        logic [1:0] event_mode;
        logic latch_readback_filter;
        logic latch_clear_policy;
    } interrupt_config_type;

    typedef enum logic [2:0] {
        PULSE_IDLE = 3'b001,
        PULSE_ON = 3'b010,
        PULSE_REST = 3'b100
    } pulse_state_type;

endpackage

/* hw/fault_interrupt_mask_latch.sv */
// Interrupt masks, latched system event status and interrupt pin generation with an APB slave.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module fault_interrupt_mask_latch #(
    parameter int ADDR_WIDTH = fault_irq_pkg::ADDR_WIDTH,
    parameter int PULSE_ON_CYCLES = fault_irq_pkg::PULSE_ON_CYCLES,
    parameter int PULSE_PERIOD_CYCLES = fault_irq_pkg::PULSE_PERIOD_CYCLES
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Live system event status: serial clock error, PLL lock, over-temperature, over-current.
    input wire logic [3:0] system_event_live,
    // Latched per-channel fault bits from the channel latches, index 0 is channel 1.
    input wire logic [3:0][7:0] channel_fault_latched,
    // Mask fields for the channel latch readback filtering.
    output logic [7:0] channel_fault_mask_field,
    output logic [7:0] fault_type_mask_field,
    // Interrupt pin.
    output logic irq_pin
);

    logic [7:0] interrupt_config;
    logic [7:0] system_event_mask_field;
    logic [3:0] system_event_latched_field;
    logic [3:0] live_prev;
    logic shown_latched;
    logic [7:0] next_interrupt_config;
    logic [7:0] next_system_event_mask_field;
    logic [7:0] next_channel_fault_mask_field;
    logic [7:0] next_fault_type_mask_field;
    logic [3:0] next_system_event_latched_field;
    logic [3:0] next_live_prev;
    logic next_shown_latched;
    logic [31:0] next_prdata;
    fault_irq_pkg::interrupt_config_type cfg;
    logic [3:0] system_event_unmasked;
    logic irq_request;
    logic request_prev;
    logic next_request_prev;
    fault_irq_pkg::pulse_state_type pulse_state;
    fault_irq_pkg::pulse_state_type next_pulse_state;
    logic [31:0] pulse_count;
    logic [31:0] next_pulse_count;
    logic irq_asserted;
    logic next_irq_pin;
    logic setup_phase;
    logic access_phase;
    logic addr_ok;

    // Splits the configuration register into its fields.
    function automatic fault_irq_pkg::interrupt_config_type decode_config(input logic [7:0] raw);
        fault_irq_pkg::interrupt_config_type c;
        c.irq_polarity_select = raw[fault_irq_pkg::POS_IRQ_POLARITY_SELECT];
        c.event_mode = raw[fault_irq_pkg::POS_EVENT_MODE_LO +: 2];
        c.latch_readback_filter = raw[fault_irq_pkg::POS_LATCH_READBACK_FILTER];
        c.latch_clear_policy = raw[fault_irq_pkg::POS_LATCH_CLEAR_POLICY];
        return c;
    endfunction

    // Returns true when the bus address selects the register at the given byte address.
    function automatic logic hits(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] reg_addr);
        return a == ADDR_WIDTH'(reg_addr);
    endfunction

    // Computes the byte-lane-0 write result of a register.
    function automatic logic [7:0] write_byte(input logic [7:0] old, input logic sel);
        return (sel && pstrb[0]) ? pwdata[7:0] : old;
    endfunction

    assign cfg = decode_config(interrupt_config);
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;

    assign addr_ok = hits(paddr, fault_irq_pkg::ADDR_INTERRUPT_CONFIG)
        || hits(paddr, fault_irq_pkg::ADDR_SYSTEM_EVENT_MASK)
        || hits(paddr, fault_irq_pkg::ADDR_CHANNEL_FAULT_MASK)
        || hits(paddr, fault_irq_pkg::ADDR_FAULT_TYPE_MASK)
        || hits(paddr, fault_irq_pkg::ADDR_SYSTEM_EVENT_LATCHED_STATUS);

    // Every transfer completes in its first access cycle; unmapped addresses answer an error.
    assign pready = access_phase;
    assign pslverr = access_phase && !addr_ok;

    // Registers, read data and latch update.
    always_comb begin
        logic wr;
        logic [3:0] set_bits;
        logic [3:0] clear_bits;
        logic [3:0] shown;
        wr = access_phase && pwrite;
        set_bits = 4'h0;
        clear_bits = 4'h0;
        shown = system_event_latched_field;
        next_interrupt_config = write_byte(interrupt_config,
            wr && hits(paddr, fault_irq_pkg::ADDR_INTERRUPT_CONFIG));
        next_system_event_mask_field = write_byte(system_event_mask_field,
            wr && hits(paddr, fault_irq_pkg::ADDR_SYSTEM_EVENT_MASK));
        next_channel_fault_mask_field = write_byte(channel_fault_mask_field,
            wr && hits(paddr, fault_irq_pkg::ADDR_CHANNEL_FAULT_MASK));
        next_fault_type_mask_field = write_byte(fault_type_mask_field,
            wr && hits(paddr, fault_irq_pkg::ADDR_FAULT_TYPE_MASK));
        if (cfg.latch_readback_filter) begin
            shown = system_event_latched_field & ~system_event_mask_field[7:4];
        end
        next_prdata = prdata;
        next_shown_latched = shown_latched;
        if (setup_phase && !pwrite) begin
            next_prdata = 32'h0000_0000;
            next_shown_latched = 1'b0;
            if (hits(paddr, fault_irq_pkg::ADDR_INTERRUPT_CONFIG)) begin
                next_prdata[7:0] = interrupt_config;
            end else if (hits(paddr, fault_irq_pkg::ADDR_SYSTEM_EVENT_MASK)) begin
                next_prdata[7:0] = system_event_mask_field;
            end else if (hits(paddr, fault_irq_pkg::ADDR_CHANNEL_FAULT_MASK)) begin
                next_prdata[7:0] = channel_fault_mask_field;
            end else if (hits(paddr, fault_irq_pkg::ADDR_FAULT_TYPE_MASK)) begin
                next_prdata[7:0] = fault_type_mask_field;
            end else if (hits(paddr, fault_irq_pkg::ADDR_SYSTEM_EVENT_LATCHED_STATUS)) begin
                next_prdata[7:0] = {shown, 4'h0};
                next_shown_latched = 1'b1;
            end
        end
        // Only bits that the completing read actually returned are cleared.
        if (access_phase && !pwrite && shown_latched) begin
            clear_bits = prdata[7:4];
        end
        if (cfg.latch_clear_policy) begin
            set_bits = system_event_live & ~live_prev;
        end else begin
            set_bits = system_event_live;
            clear_bits = clear_bits & ~system_event_live;
        end
        // A new event wins over a read clear in the same cycle; masks act here only through read data filtered by latch_readback_filter.
        next_system_event_latched_field =
            set_bits | (system_event_latched_field & ~clear_bits);
        next_live_prev = system_event_live;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_config <= fault_irq_pkg::RESET_INTERRUPT_CONFIG;
            system_event_mask_field <= fault_irq_pkg::RESET_SYSTEM_EVENT_MASK;
            channel_fault_mask_field <= fault_irq_pkg::RESET_CHANNEL_FAULT_MASK;
            fault_type_mask_field <= fault_irq_pkg::RESET_FAULT_TYPE_MASK;
            system_event_latched_field <= fault_irq_pkg::RESET_SYSTEM_EVENT_LATCHED;
            live_prev <= 4'h0;
            prdata <= 32'h0000_0000;
            shown_latched <= 1'b0;
        end else begin
            interrupt_config <= next_interrupt_config;
            system_event_mask_field <= next_system_event_mask_field;
            channel_fault_mask_field <= next_channel_fault_mask_field;
            fault_type_mask_field <= next_fault_type_mask_field;
            system_event_latched_field <= next_system_event_latched_field;
            live_prev <= next_live_prev;
            prdata <= next_prdata;
            shown_latched <= next_shown_latched;
        end
    end

    // Interrupt request from every unmasked latched source.
    always_comb begin
        logic channel_request;
        channel_request = 1'b0;
        for (int ch = 0; ch < fault_irq_pkg::CHANNEL_COUNT; ch++) begin
            if (!channel_fault_mask_field[7 - ch]) begin
                channel_request = channel_request
                    || |(channel_fault_latched[ch] & ~fault_type_mask_field);
            end
        end
        system_event_unmasked = system_event_latched_field & ~system_event_mask_field[7:4];
        irq_request = |system_event_unmasked || channel_request;
    end

    // Pin timing per event mode.
    always_comb begin
        next_pulse_state = pulse_state;
        next_pulse_count = pulse_count;
        next_request_prev = irq_request;
        irq_asserted = 1'b0;
        unique case (pulse_state)
            fault_irq_pkg::PULSE_IDLE: begin
                next_pulse_count = 32'h0000_0000;
                if (cfg.event_mode == fault_irq_pkg::EVENT_REPEAT && irq_request) begin
                    next_pulse_state = fault_irq_pkg::PULSE_ON;
                end else if (cfg.event_mode == fault_irq_pkg::EVENT_ONCE
                        && irq_request && !request_prev) begin
                    next_pulse_state = fault_irq_pkg::PULSE_ON;
                end
            end
            fault_irq_pkg::PULSE_ON: begin
                next_pulse_count = pulse_count + 32'h0000_0001;
                if (pulse_count == 32'(PULSE_ON_CYCLES - 1)) begin
                    if (cfg.event_mode == fault_irq_pkg::EVENT_REPEAT) begin
                        next_pulse_state = fault_irq_pkg::PULSE_REST;
                    end else begin
                        next_pulse_state = fault_irq_pkg::PULSE_IDLE;
                    end
                end
            end
            fault_irq_pkg::PULSE_REST: begin
                next_pulse_count = pulse_count + 32'h0000_0001;
                if (pulse_count == 32'(PULSE_PERIOD_CYCLES - 1)) begin
                    next_pulse_count = 32'h0000_0000;
                    if (irq_request && cfg.event_mode == fault_irq_pkg::EVENT_REPEAT) begin
                        next_pulse_state = fault_irq_pkg::PULSE_ON;
                    end else begin
                        next_pulse_state = fault_irq_pkg::PULSE_IDLE;
                    end
                end
            end
            default: begin
                next_pulse_state = fault_irq_pkg::PULSE_IDLE;
            end
        endcase
        if (cfg.event_mode == fault_irq_pkg::EVENT_REPEAT
                || cfg.event_mode == fault_irq_pkg::EVENT_ONCE) begin
            irq_asserted = (pulse_state == fault_irq_pkg::PULSE_ON);
        end else begin
            irq_asserted = irq_request;
        end
        next_irq_pin = cfg.irq_polarity_select ? irq_asserted : !irq_asserted;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_state <= fault_irq_pkg::PULSE_IDLE;
            pulse_count <= 32'h0000_0000;
            request_prev <= 1'b0;
            irq_pin <= 1'b1;
        end else begin
            pulse_state <= next_pulse_state;
            pulse_count <= next_pulse_count;
            request_prev <= next_request_prev;
            irq_pin <= next_irq_pin;
        end
    end

endmodule

/* verification/fault_irq_props.sv */
// Concurrent checks on the ports of the fault interrupt mask and latch block.
`timescale 1ns/1ps
module fault_irq_props #(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events, masks and interrupt pin.
    input wire logic [3:0] system_event_live,
    input wire logic [3:0][7:0] channel_fault_latched,
    input wire logic [7:0] channel_fault_mask_field,
    input wire logic [7:0] fault_type_mask_field,
    input wire logic irq_pin
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] cfg, sysmask, next_cfg, next_sysmask;
    logic wr_hit;
    assign wr_hit = psel && penable && pwrite && pstrb[0];
    // Shadow copies of the configuration and system event mask.
    always_comb begin
        next_cfg = cfg;
        next_sysmask = sysmask;
        if (wr_hit && paddr == fault_irq_pkg::ADDR_INTERRUPT_CONFIG) begin
            next_cfg = pwdata[7:0];
        end
        if (wr_hit && paddr == fault_irq_pkg::ADDR_SYSTEM_EVENT_MASK) begin
            next_sysmask = pwdata[7:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 8'h00;
            sysmask <= 8'hff;
        end else begin
            cfg <= next_cfg;
            sysmask <= next_sysmask;
        end
    end
    property p_ch_reset; $rose(presetn) |-> channel_fault_mask_field == 8'h03; endproperty
    a_ch_reset: assert property (p_ch_reset) else $error("channel mask reset value");
    property p_type_reset; $rose(presetn) |-> fault_type_mask_field == 8'h00; endproperty
    a_type_reset: assert property (p_type_reset) else $error("type mask reset value");
    property p_irq_reset; $rose(presetn) |-> irq_pin; endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("pin not idle after reset");
    property p_ch_write;
        wr_hit && paddr == fault_irq_pkg::ADDR_CHANNEL_FAULT_MASK
            |=> channel_fault_mask_field == $past(pwdata[7:0]);
    endproperty
    a_ch_write: assert property (p_ch_write) else $error("channel mask write lost");
    property p_type_write;
        wr_hit && paddr == fault_irq_pkg::ADDR_FAULT_TYPE_MASK
            |=> fault_type_mask_field == $past(pwdata[7:0]);
    endproperty
    a_type_write: assert property (p_type_write) else $error("type mask write lost");
    property p_latch_read;
        psel && !penable && !pwrite && paddr == fault_irq_pkg::ADDR_SYSTEM_EVENT_LATCHED_STATUS
            |=> prdata[3:0] == 4'h0 && prdata[31:8] == '0;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latched spare bits set");
    property p_sys_irq;
        (cfg[6:5] == 2'h0 && !cfg[0] && |(system_event_live & ~sysmask[7:4]))[*2]
            |=> irq_pin == $past(cfg[7]);
    endproperty
    a_sys_irq: assert property (p_sys_irq) else $error("event did not drive pin");
    property p_ch_irq;
        cfg[6:5] == 2'h0 && !channel_fault_mask_field[7]
            && |(channel_fault_latched[0] & ~fault_type_mask_field)
            |=> irq_pin == $past(cfg[7]);
    endproperty
    a_ch_irq: assert property (p_ch_irq) else $error("channel fault did not drive pin");
endmodule

bind fault_interrupt_mask_latch fault_irq_props #(.ADDR_WIDTH(ADDR_WIDTH)) props (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .system_event_live, .channel_fault_latched, .channel_fault_mask_field,
    .fault_type_mask_field, .irq_pin);

/* verification/host_model.sv */
// Host model that runs APB transfers toward the block.
`timescale 1ns/1ps
module host_model #(
    parameter int ADDR_WIDTH = 12
) (
    // Clock.
    input wire logic pclk,
    // APB request.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [ADDR_WIDTH-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // APB answer.
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
    end
    // Released address and write data lines turn over so a stale value is never mistaken for a live one.
    task automatic apb(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* verification/tb.sv */
// Self-checking testbench for the fault interrupt mask and latch block.
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] A_CFG = fault_irq_pkg::ADDR_INTERRUPT_CONFIG;
    localparam logic [11:0] A_SYS = fault_irq_pkg::ADDR_SYSTEM_EVENT_MASK;
    localparam logic [11:0] A_CH = fault_irq_pkg::ADDR_CHANNEL_FAULT_MASK;
    localparam logic [11:0] A_TYPE = fault_irq_pkg::ADDR_FAULT_TYPE_MASK;
    localparam logic [11:0] A_LAT = fault_irq_pkg::ADDR_SYSTEM_EVENT_LATCHED_STATUS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq_pin, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] pstrb;
    logic [3:0] live = 4'h0;
    logic [3:0][7:0] fault = '0;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    always #50 pclk = ~pclk;
    host_model #(.ADDR_WIDTH(12)) host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr);
    fault_interrupt_mask_latch #(.ADDR_WIDTH(12), .PULSE_ON_CYCLES(4), .PULSE_PERIOD_CYCLES(8))
        DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .system_event_live(live), .channel_fault_latched(fault),
        .channel_fault_mask_field(), .fault_type_mask_field(), .irq_pin);
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        host.apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, exp);
    endtask
    task automatic settle(input logic [3:0] v, input logic [31:0] f);
        @(posedge pclk);
        live <= v;
        fault <= f;
        repeat (3) @(posedge pclk);
    endtask
    task automatic irq_is(input logic v);
        #1;
        chk({31'h0000_0000, irq_pin}, {31'h0000_0000, v});
    endtask
    // Counts the cycles in which the active-low pin stands asserted.
    task automatic count_low(input int n, input int exp);
        int lows;
        lows = 0;
        repeat (n) begin
            @(posedge pclk);
            #1;
            if (irq_pin === 1'b0) begin
                lows++;
            end
        end
        chk(lows, exp);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_SYS, 32'h0000_00ff);
        rd(A_CH, 32'h0000_0003);
        rd(A_TYPE, 32'h0000_0000);
        rd(A_LAT, 32'h0000_0000);
        irq_is(1'b1);
        wr(A_TYPE, 32'h0000_00a5);
        rd(A_TYPE, 32'h0000_00a5);
        wr(A_TYPE, 32'h0000_005a);
        rd(A_TYPE, 32'h0000_005a);
        wr(A_CH, 32'h0000_0053);
        rd(A_CH, 32'h0000_0053);
        wr(A_LAT, 32'h0000_00f0);
        rd(A_LAT, 32'h0000_0000);
        host.apb(1'b0, 12'hffc, 32'h0000_0000, q, e);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        // Each unmasked event drives the pin and stays latched until read after it ends.
        wr(A_SYS, 32'h0000_000f);
        for (int i = 0; i < 4; i++) begin
            settle(4'h1 << i, 32'h0000_0000);
            irq_is(1'b0);
            rd(A_LAT, 32'h0000_0010 << i);
            settle(4'h0, 32'h0000_0000);
            rd(A_LAT, 32'h0000_0010 << i);
            rd(A_LAT, 32'h0000_0000);
            settle(4'h0, 32'h0000_0000);
            irq_is(1'b1);
        end
        // Masked events stay off the pin but still latch.
        wr(A_SYS, 32'h0000_00ff);
        settle(4'hf, 32'h0000_0000);
        irq_is(1'b1);
        settle(4'h0, 32'h0000_0000);
        wr(A_CFG, 32'h0000_0004);
        rd(A_LAT, 32'h0000_0000);
        wr(A_CFG, 32'h0000_0000);
        rd(A_LAT, 32'h0000_00f0);
        rd(A_LAT, 32'h0000_0000);
        // The second clear policy clears while the event stands and sets on a new rise.
        wr(A_CFG, 32'h0000_0001);
        settle(4'h1, 32'h0000_0000);
        rd(A_LAT, 32'h0000_0010);
        rd(A_LAT, 32'h0000_0000);
        settle(4'h0, 32'h0000_0000);
        settle(4'h1, 32'h0000_0000);
        rd(A_LAT, 32'h0000_0010);
        // Active-high polarity.
        wr(A_SYS, 32'h0000_00ef);
        wr(A_CFG, 32'h0000_0080);
        settle(4'h1, 32'h0000_0000);
        irq_is(1'b1);
        settle(4'h0, 32'h0000_0000);
        rd(A_LAT, 32'h0000_0010);
        settle(4'h0, 32'h0000_0000);
        irq_is(1'b0);
        // Channel faults pass only through both unmasked channel and fault type.
        wr(A_CFG, 32'h0000_0000);
        wr(A_CH, 32'h0000_0073);
        settle(4'h0, 32'h0000_0100);
        irq_is(1'b1);
        wr(A_TYPE, 32'h0000_0080);
        settle(4'h0, 32'h0000_0080);
        irq_is(1'b1);
        wr(A_TYPE, 32'h0000_0000);
        settle(4'h0, 32'h0000_0080);
        irq_is(1'b0);
        // Repeating mode pulses four on and four off while the request stands.
        wr(A_CFG, 32'h0000_0040);
        count_low(16, 8);
        // One-shot mode gives one pulse per rising request.
        wr(A_CFG, 32'h0000_0060);
        settle(4'h0, 32'h0000_0000);
        fault <= 32'h0000_0080;
        count_low(16, 4);
        tally_and_finish;
    end
endmodule
